// ===== sim/sp_cpu_model.sv
// CPU core and flash array model facing the self-program unit
`timescale 1ns/1ns
module sp_cpu_model #(
  parameter int DONE_DLY = 20
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input sp_pkg::sp_flash_cmd_t flash_cmd_in,
  output logic store_out,
  output logic load_out,
  output logic [15:0] ptr_out,
  output logic [15:0] data_out,
  output logic flash_done_out
);
  int busy_cnt;

  // Idle levels at time zero
  initial
  begin
    store_out = 1'b0;
    load_out = 1'b0;
    ptr_out = 16'h0000;
    data_out = 16'h0000;
  end

  // Store pulse on the edge after the call, inside the window
  // store within window
  task automatic store(input logic [15:0] p, input logic [15:0] d);
    @(posedge mclk_in);
    store_out <= 1'b1;
    ptr_out <= p;
    data_out <= d;
    @(posedge mclk_in);
    store_out <= 1'b0;
    ptr_out <= ~p;
    data_out <= ~d;
    @(posedge mclk_in);
  endtask : store

  // Load pulse; pointer scrambled once released
  task automatic load(input logic [15:0] p);
    @(posedge mclk_in);
    load_out <= 1'b1;
    ptr_out <= p;
    @(posedge mclk_in);
    load_out <= 1'b0;
    ptr_out <= ~p;
    @(posedge mclk_in);
  endtask : load

  // Flash array reports erase or write done after a fixed delay
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      busy_cnt <= 0;
      flash_done_out <= 1'b0;
    end
    else
    begin
      flash_done_out <= 1'b0;
      if (flash_cmd_in.op == sp_pkg::SP_OP_ERASE ||
          flash_cmd_in.op == sp_pkg::SP_OP_WRITE)
      begin
        busy_cnt <= busy_cnt + 1;
        if (busy_cnt == DONE_DLY)
          flash_done_out <= 1'b1;
      end
      else
        busy_cnt <= 0;
    end
  end
endmodule : sp_cpu_model

// ===== sim/tb.sv
// Self-checking testbench of the self-program unit
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end

module tb;
  localparam logic [7:0] ctrl_a = 8'hdc;
  localparam logic [7:0] lock_a = 8'he0;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic gie = 1'b0;
  logic exec_boot = 1'b0;
  logic vec_boot = 1'b0;
  logic chip_erase = 1'b0;
  logic [4:0] buf_idx = 5'h00;
  logic [31:0] rdat;
  logic [31:0] v;
  logic wreq, st, ld, done, busy, halt, irq, sup, lvalid, sden, lden;
  logic [15:0] ptr, dat, buf_dat;
  logic [7:0] ldat;
  sp_pkg::sp_flash_cmd_t cmd;
  sp_pkg::sp_prot_t prot;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;

  sp_self_program sp_self_program_i (
    .mclk_in(mclk), .rstn_in(rstn), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .store_in(st), .load_in(ld), .ptr_in(ptr), .data_pair_in(dat),
    .gie_in(gie), .exec_boot_in(exec_boot), .vectors_boot_in(vec_boot),
    .selfprog_fuse_in(1'b0), .fuse_low_in(8'ha5),
    .chip_erase_in(chip_erase), .flash_done_in(done),
    .buf_rd_idx_in(buf_idx), .buf_rd_data_out(buf_dat),
    .flash_cmd_out(cmd), .section_busy_out(busy), .cpu_halt_out(halt),
    .store_irq_out(irq), .irq_suppress_out(sup), .load_data_out(ldat),
    .load_valid_out(lvalid), .load_denied_out(lden),
    .store_denied_out(sden),
    .prot_out(prot));

  sp_cpu_model sp_cpu_model_i (
    .mclk_in(mclk), .rstn_in(rstn), .flash_cmd_in(cmd), .store_out(st),
    .load_out(ld), .ptr_out(ptr), .data_out(dat), .flash_done_out(done));

  // Free-running clock
  initial
  begin
    forever #20 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // Cut a hang short
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_of_test;
    end
  end

  // Bus write held until waitrequest is seen low
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdat <= {24'h0, d};
    wr <= 1'b1;
    do @(posedge mclk); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask : bus_wr

  // Bus read and compare of the low byte and zero upper bits
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    do @(posedge mclk); while (wreq !== 1'b0);
    v = rdat;
    rd <= 1'b0;
    `CHK("register", {24'h0, e}, v)
  endtask : reg_chk

  // Page erase command followed by its store
  task automatic erase(input logic [15:0] p);
    bus_wr(ctrl_a, 8'h03);
    sp_cpu_model_i.store(p, 16'h0000);
  endtask : erase

  // Lock set; high data byte must be ignored
  task automatic lock_set(input logic [7:0] d);
    bus_wr(ctrl_a, 8'h09);
    sp_cpu_model_i.store(16'h0000, {8'hff, d});
    repeat (2) @(posedge mclk);
  endtask : lock_set

  // Wait for a running erase or write to finish
  task automatic wait_idle;
    while (cmd.op !== sp_pkg::SP_OP_NONE) @(posedge mclk);
  endtask : wait_idle

  // Main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    reg_chk(ctrl_a, 8'h00);
    reg_chk(lock_a, 8'hff);
    reg_chk(8'h00, 8'h00);
    bus_wr(ctrl_a, 8'hff);
    reg_chk(ctrl_a, 8'h80);
    gie <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("irq", 1'b1, irq)
    bus_wr(ctrl_a, 8'h00);
    reg_chk(ctrl_a, 8'h00);
    `CHK("irq", 1'b0, irq)
    // Fill ignores the pointer lsb
    bus_wr(ctrl_a, 8'h01);
    sp_cpu_model_i.store(16'h0007, 16'hbeef);
    `CHK("op", sp_pkg::SP_OP_FILL, cmd.op)
    buf_idx <= 5'h03;
    repeat (2) @(posedge mclk);
    `CHK("buffer", 16'hbeef, buf_dat)
    reg_chk(ctrl_a, 8'h00);
    // Late store refused, restarted window reaches its last edge
    bus_wr(ctrl_a, 8'h01);
    repeat (5) @(posedge mclk);
    sp_cpu_model_i.store(16'h0002, 16'h1111);
    `CHK("denied", 1'b1, sden)
    `CHK("op", sp_pkg::SP_OP_NONE, cmd.op)
    bus_wr(ctrl_a, 8'h01);
    repeat (2) @(posedge mclk);
    bus_wr(ctrl_a, 8'h01);
    repeat (2) @(posedge mclk);
    sp_cpu_model_i.store(16'h0002, 16'h1111);
    `CHK("op", sp_pkg::SP_OP_FILL, cmd.op)
    // Re-enable while loading drops the buffer
    bus_wr(ctrl_a, 8'h11);
    repeat (2) @(posedge mclk);
    `CHK("buffer", 16'h0000, buf_dat)
    repeat (5) @(posedge mclk);
    // Erase of a read-while-write page
    erase(16'h0080);
    `CHK("op", sp_pkg::SP_OP_ERASE, cmd.op)
    `CHK("ptr", 16'h0080, cmd.ptr)
    `CHK("busy", 1'b1, busy)
    reg_chk(ctrl_a, 8'h43);
    bus_wr(ctrl_a, 8'h11);
    reg_chk(ctrl_a, 8'h43);
    wait_idle;
    reg_chk(ctrl_a, 8'h40);
    bus_wr(ctrl_a, 8'h11);
    sp_cpu_model_i.store(16'h0000, 16'h0000);
    `CHK("busy", 1'b0, busy)
    erase(16'h0080);
    wait_idle;
    bus_wr(ctrl_a, 8'h01);
    sp_cpu_model_i.store(16'h0000, 16'h2222);
    `CHK("busy", 1'b0, busy)
    // Page write into the no-rww section halts the core
    bus_wr(ctrl_a, 8'h05);
    sp_cpu_model_i.store(16'h1800, 16'h0000);
    `CHK("op", sp_pkg::SP_OP_WRITE, cmd.op)
    `CHK("halt", 1'b1, halt)
    wait_idle;
    @(posedge mclk);
    `CHK("halt", 1'b0, halt)
    // Application locks go in before the memory lock
    lock_set(8'h3b);
    lock_set(8'h3a);
    reg_chk(lock_a, 8'hfa);
    `CHK("prot", 4'b1010, prot)
    erase(16'h0080);
    `CHK("denied", 1'b1, sden)
    bus_wr(ctrl_a, 8'h09);
    sp_cpu_model_i.load(16'h0001);
    `CHK("lvalid", 1'b1, lvalid)
    `CHK("load", 8'hfa, ldat)
    bus_wr(ctrl_a, 8'h09);
    sp_cpu_model_i.load(16'h0000);
    `CHK("load", 8'ha5, ldat)
    // Load on the fourth edge is past the window
    bus_wr(ctrl_a, 8'h09);
    repeat (2) @(posedge mclk);
    sp_cpu_model_i.load(16'h0001);
    `CHK("lvalid", 1'b0, lvalid)
    lock_set(8'h30);
    `CHK("prot", 4'b1111, prot)
    vec_boot <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("suppress", 1'b1, sup)
    exec_boot <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("suppress", 1'b0, sup)
    // Boot code reading the application section
    sp_cpu_model_i.load(16'h0080);
    `CHK("ldeny", 1'b1, lden)
    // Boot lock mode 3: suppression and application-side reads
    lock_set(8'h00);
    vec_boot <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("suppress", 1'b1, sup)
    exec_boot <= 1'b0;
    sp_cpu_model_i.load(16'h1800);
    `CHK("ldeny", 1'b1, lden)
    lock_set(8'h3f);
    reg_chk(lock_a, 8'hc0);
    chip_erase <= 1'b1;
    @(posedge mclk);
    chip_erase <= 1'b0;
    repeat (2) @(posedge mclk);
    reg_chk(lock_a, 8'hff);
    end_of_test;
  end
endmodule : tb

// ===== verilog/sp_defines.svh
// Offsets, field positions, codes and cycle counts of the self-program unit
`ifndef SP_DEFINES_SVH
`define SP_DEFINES_SVH

// Register indices; byte address is four times the index
`define SP_CTRL_IDX 6'h37
`define SP_LOCK_IDX 6'h38

// Control register field positions
`define SP_BIT_ENABLE 0
`define SP_BIT_ERASE 1
`define SP_BIT_WRITE 2
`define SP_BIT_LOCKSET 3
`define SP_BIT_REENABLE 4
`define SP_BIT_IRQ_EN 7

// Legal lower-five-bit command codes
`define SP_CODE_REENABLE 5'h11
`define SP_CODE_LOCKSET 5'h09
`define SP_CODE_WRITE 5'h05
`define SP_CODE_ERASE 5'h03
`define SP_CODE_FILL 5'h01

// Lock byte field positions
`define SP_LK_MEM_LOW 0
`define SP_LK_MEM_HIGH 1
`define SP_LK_APP_LOW 2
`define SP_LK_APP_HIGH 3
`define SP_LK_BOOT_LOW 4
`define SP_LK_BOOT_HIGH 5

// Reset values
`define SP_CTRL_RESET 8'h00
`define SP_LOCK_RESET 6'h3f
`define SP_LOCK_PAD 2'h3

// Cycle windows after a control write
`define SP_STORE_WINDOW 3'h4
`define SP_LOAD_WINDOW 2'h3

`endif

// ===== verilog/sp_pkg.sv
// Types shared by the self-program unit
package sp_pkg;

  // Operation handed to the flash array
  typedef enum logic [2:0] {
    SP_OP_NONE,
    SP_OP_FILL,
    SP_OP_ERASE,
    SP_OP_WRITE,
    SP_OP_LOCK
  } sp_op_t;

  // Command pulse to the flash array
  typedef struct packed {
    sp_op_t op;
    logic [15:0] ptr;
    logic [15:0] data;
  } sp_flash_cmd_t;

  // Protection levels seen by the programming ports
  typedef struct packed {
    logic write_block;
    logic verify_block;
    logic fuse_lock;
    logic boot_lock_lock;
  } sp_prot_t;

endpackage : sp_pkg

// ===== verilog/sp_self_program.sv
// Self-program control, page buffer and lock bits with Avalon-MM slave
`timescale 1ns/1ns
`include "sp_defines.svh"

module sp_self_program #(
  parameter int WORD_BITS = 5,
  parameter int NO_READWHILEWRITE_SECTION_PAGE = 96,
  parameter int BOOT_PAGE = 96,
  parameter bit HAS_BOOT = 1'b1
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic store_in,
  input wire logic load_in,
  input wire logic [15:0] ptr_in,
  input wire logic [15:0] data_pair_in,
  input wire logic gie_in,
  input wire logic exec_boot_in,
  input wire logic vectors_boot_in,
  input wire logic selfprog_fuse_in,
  input wire logic [7:0] fuse_low_in,
  input wire logic chip_erase_in,
  input wire logic flash_done_in,
  input wire logic [WORD_BITS-1:0] buf_rd_idx_in,
  output logic [15:0] buf_rd_data_out,
  output sp_pkg::sp_flash_cmd_t flash_cmd_out,
  output logic section_busy_out,
  output logic cpu_halt_out,
  output logic store_irq_out,
  output logic irq_suppress_out,
  output logic [7:0] load_data_out,
  output logic load_valid_out,
  output logic load_denied_out,
  output logic store_denied_out,
  output sp_pkg::sp_prot_t prot_out
);

  localparam int WORDS = 1 << WORD_BITS;
  localparam int PG_BITS = 15 - WORD_BITS;

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic irq_en_reg;
  logic [4:0] cmd_reg;
  logic [2:0] win_reg;
  logic [1:0] lwin_reg;
  logic flash_reg;
  logic halt_reg;
  logic busy_reg;
  logic filled_reg;
  logic [5:0] lock_reg;
  logic [15:0] buf_reg [WORDS];
  logic [15:0] bufq_reg;
  sp_pkg::sp_flash_cmd_t fcmd_reg;
  logic irq_reg;
  logic supp_reg;
  logic [7:0] ldata_reg;
  logic lvalid_reg;
  logic ldeny_reg;
  logic sdeny_reg;
  sp_pkg::sp_prot_t prot_reg;

  logic acc_go;
  logic ctrl_wr;
  logic [4:0] wr_low;
  logic legal;
  logic store_go;
  logic [PG_BITS-1:0] page;
  logic in_boot;
  logic in_no_readwhilewrite_section;
  logic sect_ok;
  logic launch;
  logic fill_go;
  logic lock_go;
  logic reen_go;
  logic [7:0] ctrl_rd;

  // Bus handshake and decode
  assign acc_go = (avs_read_in | avs_write_in) & ~wait_reg;
  assign ctrl_wr = acc_go & avs_write_in &
    avs_address_in[7:2] == `SP_CTRL_IDX & avs_address_in[1:0] == 2'h0;
  assign wr_low = avs_writedata_in[4:0];
  assign ctrl_rd = {irq_en_reg, busy_reg, 1'b0, cmd_reg};

  // Legal command codes
  always_comb
  begin
    case (wr_low)
      `SP_CODE_REENABLE, `SP_CODE_LOCKSET, `SP_CODE_WRITE,
      `SP_CODE_ERASE, `SP_CODE_FILL: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  // Target page and section checks
  assign page = ptr_in[15:WORD_BITS+1];
  assign in_boot = HAS_BOOT && page >= PG_BITS'(BOOT_PAGE);
  assign in_no_readwhilewrite_section = page >= PG_BITS'(NO_READWHILEWRITE_SECTION_PAGE);
  assign sect_ok = in_boot ? lock_reg[`SP_LK_BOOT_LOW] :
    lock_reg[`SP_LK_APP_LOW];
  assign store_go = store_in & cmd_reg[`SP_BIT_ENABLE] & win_reg != 3'h0 &
    ~flash_reg & (HAS_BOOT || ~selfprog_fuse_in);
  assign launch = store_go & (cmd_reg == `SP_CODE_ERASE |
    cmd_reg == `SP_CODE_WRITE) & (!HAS_BOOT || sect_ok);
  assign fill_go = store_go & cmd_reg == `SP_CODE_FILL;
  assign lock_go = store_go & cmd_reg == `SP_CODE_LOCKSET;
  assign reen_go = store_go & cmd_reg == `SP_CODE_REENABLE;

  // Avalon slave: one wait cycle, then answer
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end
    else
    begin
      wait_reg <= ~((avs_read_in | avs_write_in) & wait_reg);
      if (avs_read_in & wait_reg & avs_address_in[1:0] == 2'h0)
      begin
        if (avs_address_in[7:2] == `SP_CTRL_IDX)
          rdata_reg <= {24'h0, ctrl_rd};
        else if (avs_address_in[7:2] == `SP_LOCK_IDX)
          rdata_reg <= {24'h0, `SP_LOCK_PAD, lock_reg};
        else
          rdata_reg <= 32'h0;
      end
      else if (avs_read_in & wait_reg)
        rdata_reg <= 32'h0;
    end
  end

  // Command bits and store window
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      irq_en_reg <= 1'(`SP_CTRL_RESET >> `SP_BIT_IRQ_EN);
      cmd_reg <= 5'(`SP_CTRL_RESET);
      win_reg <= 3'h0;
      lwin_reg <= 2'h0;
    end
    else
    begin
      if (ctrl_wr)
        irq_en_reg <= avs_writedata_in[`SP_BIT_IRQ_EN];
      if (lwin_reg != 2'h0)
        lwin_reg <= lwin_reg - 2'h1;
      if (flash_reg)
      begin
        if (flash_done_in)
          cmd_reg <= 5'h0;
      end
      else if (ctrl_wr & legal)
      begin
        cmd_reg <= wr_low;
        win_reg <= `SP_STORE_WINDOW;
        lwin_reg <= wr_low == `SP_CODE_LOCKSET ? `SP_LOAD_WINDOW : 2'h0;
      end
      else if (store_go)
      begin
        win_reg <= 3'h0;
        if (!launch)
          cmd_reg <= 5'h0;
      end
      else if (win_reg != 3'h0)
      begin
        win_reg <= win_reg - 3'h1;
        if (win_reg == 3'h1)
          cmd_reg <= 5'h0;
      end
    end
  end

  // Running erase or write, CPU halt
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      flash_reg <= 1'b0;
      halt_reg <= 1'b0;
    end
    else if (flash_reg & flash_done_in)
    begin
      flash_reg <= 1'b0;
      halt_reg <= 1'b0;
    end
    else if (launch)
    begin
      flash_reg <= 1'b1;
      halt_reg <= in_no_readwhilewrite_section;
    end
  end

  // Section busy flag
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      busy_reg <= 1'b0;
    else if (launch & ~in_no_readwhilewrite_section)
      busy_reg <= 1'b1;
    else if (reen_go | fill_go)
      busy_reg <= 1'b0;
  end

  // Temporary page buffer
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      filled_reg <= 1'b0;
      bufq_reg <= 16'h0;
      for (int i = 0; i < WORDS; i++)
        buf_reg[i] <= 16'h0;
    end
    else
    begin
      bufq_reg <= buf_reg[buf_rd_idx_in];
      if ((ctrl_wr & wr_low == `SP_CODE_REENABLE & filled_reg) |
          (flash_reg & flash_done_in & fcmd_reg.op == sp_pkg::SP_OP_WRITE))
      begin
        filled_reg <= 1'b0;
        for (int i = 0; i < WORDS; i++)
          buf_reg[i] <= 16'h0;
      end
      else if (fill_go)
      begin
        filled_reg <= 1'b1;
        buf_reg[ptr_in[WORD_BITS:1]] <= data_pair_in;
      end
    end
  end

  // Command pulse to flash array
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      fcmd_reg <= '{op: sp_pkg::SP_OP_NONE, ptr: 16'h0, data: 16'h0};
    else if (store_go)
    begin
      fcmd_reg.ptr <= ptr_in;
      fcmd_reg.data <= data_pair_in;
      if (launch)
        fcmd_reg.op <= cmd_reg == `SP_CODE_WRITE ? sp_pkg::SP_OP_WRITE :
          sp_pkg::SP_OP_ERASE;
      else if (fill_go)
        fcmd_reg.op <= sp_pkg::SP_OP_FILL;
      else if (lock_go)
        fcmd_reg.op <= sp_pkg::SP_OP_LOCK;
      else
        fcmd_reg.op <= sp_pkg::SP_OP_NONE;
    end
    else if (!flash_reg)
      fcmd_reg.op <= sp_pkg::SP_OP_NONE;
  end

  // Lock bits
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      lock_reg <= `SP_LOCK_RESET;
    else if (chip_erase_in)
      lock_reg <= `SP_LOCK_RESET;
    else if (lock_go)
      lock_reg <= lock_reg & data_pair_in[5:0];
  end

  // Load path: lock/fuse reads and read protection
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ldata_reg <= 8'h0;
      lvalid_reg <= 1'b0;
      ldeny_reg <= 1'b0;
    end
    else
    begin
      lvalid_reg <= 1'b0;
      ldeny_reg <= 1'b0;
      // lock or fuse by bit zero
      if (load_in & lwin_reg != 2'h0 & cmd_reg == `SP_CODE_LOCKSET)
      begin
        lvalid_reg <= 1'b1;
        ldata_reg <= ptr_in[0] ? {`SP_LOCK_PAD, lock_reg} : fuse_low_in;
      end
      else if (load_in)
        ldeny_reg <= (HAS_BOOT && (
          (exec_boot_in & ~in_boot & ~lock_reg[`SP_LK_APP_HIGH]) |
          (~exec_boot_in & in_boot & ~lock_reg[`SP_LK_BOOT_HIGH]))) |
          (busy_reg & ~in_no_readwhilewrite_section);
    end
  end

  // Interrupts, refused stores, protection levels
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      irq_reg <= 1'b0;
      supp_reg <= 1'b0;
      sdeny_reg <= 1'b0;
      prot_reg <= '0;
    end
    else
    begin
      irq_reg <= irq_en_reg & gie_in & ~cmd_reg[`SP_BIT_ENABLE];
      supp_reg <= HAS_BOOT && (
        (vectors_boot_in & ~exec_boot_in & ~lock_reg[`SP_LK_APP_HIGH]) |
        (~vectors_boot_in & exec_boot_in & ~lock_reg[`SP_LK_BOOT_HIGH]));
      sdeny_reg <= store_in & ~store_go |
        store_go & (cmd_reg == `SP_CODE_ERASE |
        cmd_reg == `SP_CODE_WRITE) & ~launch;
      prot_reg.write_block <= ~lock_reg[`SP_LK_MEM_LOW];
      prot_reg.fuse_lock <= ~lock_reg[`SP_LK_MEM_LOW];
      prot_reg.verify_block <= ~lock_reg[`SP_LK_MEM_LOW] &
        ~lock_reg[`SP_LK_MEM_HIGH];
      prot_reg.boot_lock_lock <= ~lock_reg[`SP_LK_MEM_LOW] &
        ~lock_reg[`SP_LK_MEM_HIGH];
    end
  end

  // Outputs straight from flops
  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out = rdata_reg;
  assign buf_rd_data_out = bufq_reg;
  assign flash_cmd_out = fcmd_reg;
  assign section_busy_out = busy_reg;
  assign cpu_halt_out = halt_reg;
  assign store_irq_out = irq_reg;
  assign irq_suppress_out = supp_reg;
  assign load_data_out = ldata_reg;
  assign load_valid_out = lvalid_reg;
  assign load_denied_out = ldeny_reg;
  assign store_denied_out = sdeny_reg;
  assign prot_out = prot_reg;

  // Checks next to the logic
  window_expiry_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    ctrl_wr & legal & ~flash_reg ##1 (~store_in & ~ctrl_wr)[*4]
    |=> cmd_reg == 5'h0)
    else $error("enable bit survived its window");
  busy_set_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    launch & ~in_no_readwhilewrite_section |=> busy_reg & flash_reg)
    else $error("busy flag not set on section operation");
  busy_fill_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    fill_go |=> ~busy_reg)
    else $error("busy flag not cleared by buffer fill");
  irq_level_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    store_irq_out |-> $past(irq_en_reg) & $past(gie_in) &
      ~$past(cmd_reg[0]))
    else $error("ready irq without its causes");
  reserved_zero_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    ~wait_reg & $past(avs_address_in[7:2] == `SP_CTRL_IDX) &
      $past(avs_read_in) |-> avs_readdata_out[5] == 1'b0)
    else $error("reserved control bit read as one");
  illegal_write_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    ctrl_wr & ~legal & ~store_in & win_reg == 3'h0 & ~flash_reg
    |=> cmd_reg == $past(cmd_reg))
    else $error("illegal command code changed control bits");
  lock_rise_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    ~chip_erase_in |=> (lock_reg & ~$past(lock_reg)) == 6'h0)
    else $error("lock bit returned to one without chip erase");
  halt_hold_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    cpu_halt_out |-> flash_reg & cmd_reg[0])
    else $error("cpu halted with no page operation");
  late_store_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    store_in & win_reg == 3'h0 & ~flash_reg
    |=> flash_cmd_out.op == sp_pkg::SP_OP_NONE)
    else $error("store outside window started an operation");
  prot_mode_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    lock_reg[1:0] == 2'h0 ##1 lock_reg[1:0] == 2'h0
    |-> prot_out.verify_block & prot_out.write_block)
    else $error("mode 3 protection missing");

endmodule : sp_self_program
